// File: pmc_pkg.sv
// Purpose: shared constants and types for the power mode controller
// Assumes: subsystem enables are one bit per subsystem
// Notes:   no bus; control and status bits are plain ports
`default_nettype none

package pmc_pkg;

	// ==========================================================
	// subsystem map
	localparam int unsigned PMC_NSUB      = 8;
	localparam int unsigned PMC_SUB_CPU   = 0;
	localparam int unsigned PMC_SUB_FLASH = 1;
	localparam logic [7:0]  PMC_TPL_ACT_RST = 8'hFF;
	localparam logic [7:0]  PMC_TPL_ALT_RST = 8'hFE;

	// ==========================================================
	// wakeup source map
	localparam int unsigned PMC_NWAKE     = 6;
	localparam int unsigned PMC_WK_CMP    = 0;
	localparam int unsigned PMC_WK_PORT   = 1;
	localparam int unsigned PMC_WK_I2C    = 2;
	localparam int unsigned PMC_WK_RTC    = 3;
	localparam int unsigned PMC_WK_TWHEEL = 4;
	localparam int unsigned PMC_WK_LVD    = 5;
	localparam logic [5:0]  PMC_SLEEP_WK_MASK = 6'h3F;
	localparam logic [5:0]  PMC_HIB_WK_MASK   = 6'h02;

	// ==========================================================
	// mode select codes and regulator pulsing
	localparam logic [1:0]  PMC_REQ_ALT   = 2'h1;
	localparam logic [1:0]  PMC_REQ_SLEEP = 2'h2;
	localparam logic [1:0]  PMC_REQ_HIB   = 2'h3;
	localparam int unsigned PMC_BUZZ_W    = 8;
	localparam logic [7:0]  PMC_BUZZ_PERIOD = 8'hFF;
	localparam logic [7:0]  PMC_BUZZ_ON     = 8'h03;

	typedef enum logic [1:0] {
		PMC_ACTIVE,
		PMC_ALT_ACTIVE,
		PMC_SLEEP,
		PMC_HIBERNATE
	} pmc_mode_t;

	typedef struct packed {
		logic [7:0] clk_en;
		logic [7:0] bias_en;
		logic [7:0] leak_cut;
	} pmc_sub_ctl_t;

	typedef struct packed {
		logic internal_low_speed_osc;
		logic watch_crystal_osc;
		logic fast_clocks;
	} pmc_clk_ctl_t;

	typedef struct packed {
		logic digital_core_supply;
		logic analog_core_supply;
		logic hibernate_reg;
	} pmc_reg_ctl_t;

endpackage : pmc_pkg

`default_nettype wire

// File: pmc_wake_filter.sv
// Purpose: masks wakeup sources by the current mode
// Assumes: sources are synchronous single-cycle or level events
// Notes:   output is combinational, registered in the top
`default_nettype none
`timescale 1ns/1ps

module pmc_wake_filter
	import pmc_pkg::*;
(
	input  wire logic [5:0] i_wake,
	input  wire logic       i_reset_evt,
	input  wire pmc_mode_t  i_mode,
	output logic            o_wake
);

	// ==========================================================
	// source gating
	logic [5:0] allowed;

	always_comb begin
		case (i_mode)
			PMC_SLEEP:     allowed = PMC_SLEEP_WK_MASK;
			PMC_HIBERNATE: allowed = PMC_HIB_WK_MASK;
			default:       allowed = 6'h3F;
		endcase
	end

	// disallowed sources simply drop out
	assign o_wake = (|(i_wake & allowed)) | i_reset_evt;

endmodule // pmc_wake_filter

`default_nettype wire

// File: pmc_buzz.sv
// Purpose: periodic pulse generator for core regulators in sleep
// Assumes: enabled only while in sleep
// Notes:   duty from package constants
`default_nettype none
`timescale 1ns/1ps

module pmc_buzz
	import pmc_pkg::*;
(
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	input  wire logic i_enable,
	output logic      o_pulse
);

	// ==========================================================
	// counter
	logic [PMC_BUZZ_W-1:0] cnt_q;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= 8'h00;
		end else if (!i_enable || cnt_q == PMC_BUZZ_PERIOD) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	assign o_pulse = i_enable && (cnt_q < PMC_BUZZ_ON);

endmodule // pmc_buzz

`default_nettype wire

// File: pmc_power_mode_ctrl.sv
// Purpose: global power mode controller with per-mode templates
// Assumes: firmware strobes and wake events synchronous to i_clock
// Notes:   all outputs registered; no bus, all controls are ports
//
// Behaviour
// - four modes: active, alternate, sleep, hibernate
// - separate enable template for active and alternate active
// - active template selects enabled resources
// - disabled: clock gated, bias off, leakage cut
// - template changes apply immediately, no transition
// - CPU may disable itself; wake re-enables
// - wakeup returns to active, CPU forced on
// - boot comes up in active
// - alternate active uses its own template
// - sleep overrides templates, disables most resources
// - sleep keeps only low-speed and watch clocks
// - sleep wake sources: six listed events
// - core regulators pulsed during sleep
// - hibernate stops clocks; port interrupt wakes
// - core regulators default on; firmware disables
// - interrupt or reset wakeup restores active
// - hibernate holds outputs and pin interrupts
`default_nettype none
`timescale 1ns/1ps

module pmc_power_mode_ctrl
	import pmc_pkg::*;
(
	input  wire logic               i_clock,
	input  wire logic               i_resetn,
	input  wire logic               i_tpl_act_we,
	input  wire logic [7:0]         i_tpl_act,
	input  wire logic               i_tpl_alt_we,
	input  wire logic [7:0]         i_tpl_alt,
	input  wire logic               i_cpu_off,
	input  wire logic               i_mode_we,
	input  wire logic [1:0]         i_mode_sel,
	input  wire logic               i_io_supply_ok,
	input  wire logic               i_core_reg_off_we,
	input  wire logic [1:0]         i_core_reg_off,
	input  wire logic [5:0]         i_wake,
	input  wire logic               i_reset_evt,
	input  wire logic [7:0]         i_pin_out,
	input  wire logic [7:0]         i_pin_irq_cfg,
	output pmc_mode_t               o_mode,
	output pmc_sub_ctl_t            o_sub,
	output pmc_clk_ctl_t            o_clk,
	output pmc_reg_ctl_t            o_reg,
	output logic [7:0]              o_pin_out,
	output logic [7:0]              o_pin_irq_cfg,
	output logic                    o_retain,
	output logic                    o_req_refused
);

	// ==========================================================
	// reset release
	logic rst_s1_q;
	logic rst_n;

	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// ==========================================================
	// helpers
	function automatic logic [7:0] pmc_apply_cpu(input logic [7:0] t, input logic on);
		logic [7:0] r;
		r = t;
		r[PMC_SUB_CPU] = on;
		return r;
	endfunction

	// ==========================================================
	// submodules
	pmc_mode_t mode_q;
	logic      wake;
	logic      buzz;

	pmc_wake_filter u_wake (
		.i_wake      (i_wake),
		.i_reset_evt (i_reset_evt),
		.i_mode      (mode_q),
		.o_wake      (wake)
	);

	pmc_buzz u_buzz (
		.i_clock  (i_clock),
		.i_rst_n  (rst_n),
		.i_enable (mode_q == PMC_SLEEP),
		.o_pulse  (buzz)
	);

	// ==========================================================
	// templates
	logic [7:0] tpl_act_q;
	logic [7:0] tpl_alt_q;

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			tpl_act_q <= PMC_TPL_ACT_RST;
			tpl_alt_q <= PMC_TPL_ALT_RST;
		end else begin
			if (i_tpl_act_we) begin
				tpl_act_q <= i_tpl_act;
			end
			if (i_tpl_alt_we) begin
				tpl_alt_q <= i_tpl_alt;
			end
		end
	end

	// ==========================================================
	// cpu self disable; wake wins over a same-cycle disable
	logic cpu_on_q;

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			cpu_on_q <= 1'b1;
		end else if (wake) begin
			cpu_on_q <= 1'b1;
		end else if (i_cpu_off) begin
			cpu_on_q <= 1'b0;
		end else if (i_tpl_act_we) begin
			// template write sets the cpu bit unless a wake or cpu disable comes in the same cycle
			cpu_on_q <= i_tpl_act[PMC_SUB_CPU];
		end
	end

	// ==========================================================
	// mode state machine
	logic refused_q;

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_q    <= PMC_ACTIVE;
			refused_q <= 1'b0;
		end else begin
			refused_q <= 1'b0;
			if (wake) begin
				mode_q <= PMC_ACTIVE;
			end else if (i_mode_we && (mode_q == PMC_ACTIVE || mode_q == PMC_ALT_ACTIVE)) begin
				case (i_mode_sel)
					PMC_REQ_ALT: begin
						mode_q <= PMC_ALT_ACTIVE;
					end
					PMC_REQ_SLEEP: begin
						// low power only on valid io supplies
						if (i_io_supply_ok) begin
							mode_q <= PMC_SLEEP;
						end else begin
							refused_q <= 1'b1;
						end
					end
					PMC_REQ_HIB: begin
						if (i_io_supply_ok) begin
							mode_q <= PMC_HIBERNATE;
						end else begin
							refused_q <= 1'b1;
						end
					end
					default: begin
						mode_q <= PMC_ACTIVE;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// core regulator enables
	logic [1:0] core_off_q;

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			core_off_q <= 2'h0;
		end else if (i_core_reg_off_we) begin
			core_off_q <= i_core_reg_off;
		end
	end

	// ==========================================================
	// output decode
	logic [7:0]   en_d;
	pmc_clk_ctl_t clk_d;
	pmc_reg_ctl_t reg_d;

	always_comb begin
		en_d  = 8'h00;
		clk_d = '0;
		reg_d = '0;
		case (mode_q)
			PMC_ACTIVE: begin
				en_d  = pmc_apply_cpu(tpl_act_q, cpu_on_q);
				clk_d = '{1'b1, 1'b1, 1'b1};
				reg_d = '{~core_off_q[0], ~core_off_q[1], 1'b0};
			end
			PMC_ALT_ACTIVE: begin
				en_d  = tpl_alt_q & {7'h7F, cpu_on_q};
				clk_d = '{1'b1, 1'b1, 1'b1};
				reg_d = '{~core_off_q[0], ~core_off_q[1], 1'b0};
			end
			PMC_SLEEP: begin
				en_d  = 8'h00;
				clk_d = '{1'b1, 1'b1, 1'b0};
				// buzzed so the rails stay near level for fast resume
				reg_d = '{buzz & ~core_off_q[0], buzz & ~core_off_q[1], 1'b0};
			end
			default: begin
				en_d  = 8'h00;
				clk_d = '0;
				reg_d = '{1'b0, 1'b0, 1'b1};
			end
		endcase
	end

	// ==========================================================
	// registered outputs
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			o_mode        <= PMC_ACTIVE;
			o_sub         <= '0;
			o_clk         <= '0;
			o_reg         <= '0;
			o_retain      <= 1'b0;
			o_req_refused <= 1'b0;
		end else begin
			o_mode        <= mode_q;
			o_sub.clk_en  <= en_d;
			o_sub.bias_en <= en_d;
			o_sub.leak_cut <= ~en_d;
			o_clk         <= clk_d;
			o_reg         <= reg_d;
			o_retain      <= (mode_q == PMC_HIBERNATE);
			o_req_refused <= refused_q;
		end
	end

	// pins freeze while hibernating
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			o_pin_out     <= 8'h00;
			o_pin_irq_cfg <= 8'h00;
		end else if (mode_q != PMC_HIBERNATE) begin
			o_pin_out     <= i_pin_out;
			o_pin_irq_cfg <= i_pin_irq_cfg;
		end
	end

endmodule // pmc_power_mode_ctrl

`default_nettype wire

// File: pmc_power_mode_ctrl_properties.sv
// Purpose: port assertions for the power mode controller
// Assumes: a request or wake taken at edge k shows at edge k+2
// Notes:   o_mode at edge k+1 gives the mode held at edge k
`timescale 1ns/1ps
`default_nettype none
module pmc_props
	import pmc_pkg::*;
(
	input wire logic         i_clock,
	input wire logic         i_resetn,
	input wire logic         i_tpl_act_we,
	input wire logic [7:0]   i_tpl_act,
	input wire logic         i_cpu_off,
	input wire logic         i_mode_we,
	input wire logic [1:0]   i_mode_sel,
	input wire logic         i_io_supply_ok,
	input wire logic [5:0]   i_wake,
	input wire logic         i_reset_evt,
	input wire pmc_mode_t    o_mode,
	input wire pmc_sub_ctl_t o_sub,
	input wire pmc_clk_ctl_t o_clk,
	input wire pmc_reg_ctl_t o_reg,
	input wire logic         o_retain,
	input wire logic         o_req_refused
);
	// ==========
	// helpers
	wire logic quiet = (i_wake == 6'h00) && !i_reset_evt;
	wire logic run   = (o_mode == PMC_ACTIVE) || (o_mode == PMC_ALT_ACTIVE);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	// ==========
	// properties
	a_boot_active: assert property (
		$rose(i_resetn) |-> ##3 o_mode == PMC_ACTIVE && o_reg == 3'h6) else $error("boot mode");
	a_sleep_gated: assert property (
		o_mode == PMC_SLEEP |-> o_sub.clk_en == 8'h00 && o_clk == 3'h6) else $error("sleep gating");
	a_hib_stopped: assert property (
		o_mode == PMC_HIBERNATE |-> o_clk == 3'h0 && o_reg == 3'h1 && o_retain) else $error("hib");
	a_leak_cut: assert property (
		o_sub.clk_en != 8'h00 |-> o_sub.leak_cut == ~o_sub.clk_en && o_sub.bias_en == o_sub.clk_en)
		else $error("disable set");
	a_sleep_wake: assert property (
		(i_wake != 6'h00 ##1 o_mode == PMC_SLEEP) |=> o_mode == PMC_ACTIVE
		&& o_sub.clk_en[PMC_SUB_CPU]) else $error("sleep wake");
	a_hib_wake: assert property (
		((i_wake[PMC_WK_PORT] || i_reset_evt) ##1 o_mode == PMC_HIBERNATE) |=> o_mode == PMC_ACTIVE)
		else $error("hib wake");
	a_hib_holds: assert property (
		(!i_wake[PMC_WK_PORT] && !i_reset_evt ##1 o_mode == PMC_HIBERNATE)
		|=> o_mode == PMC_HIBERNATE) else $error("hib left");
	a_sleep_entry: assert property (
		(i_mode_we && i_mode_sel == PMC_REQ_SLEEP && i_io_supply_ok && quiet ##1 run)
		|=> o_mode == PMC_SLEEP) else $error("no sleep");
	a_refuse_pulse: assert property (
		(i_mode_we && i_mode_sel[1] && !i_io_supply_ok && quiet
		##1 run && !(i_mode_we && !i_io_supply_ok))
		|=> o_req_refused ##1 !o_req_refused) else $error("refusal pulse");
	a_cpu_self_off: assert property (
		(i_cpu_off && quiet ##1 o_mode == PMC_ACTIVE) |=> !o_sub.clk_en[PMC_SUB_CPU])
		else $error("cpu still on");
	a_tpl_apply: assert property (
		(i_tpl_act_we && !i_cpu_off && !i_mode_we && quiet ##1 o_mode == PMC_ACTIVE)
		|=> o_sub.clk_en == $past(i_tpl_act, 2)) else $error("template");
endmodule // pmc_props
bind pmc_power_mode_ctrl pmc_props u_props (.i_clock, .i_resetn, .i_tpl_act_we, .i_tpl_act,
	.i_cpu_off, .i_mode_we, .i_mode_sel, .i_io_supply_ok, .i_wake, .i_reset_evt, .o_mode,
	.o_sub, .o_clk, .o_reg, .o_retain, .o_req_refused);
`default_nettype wire

// File: pmc_fw_model.sv
// Purpose: firmware and wake source model driving the controller
// Assumes: all strobes one cycle wide, launched at the falling edge
// Notes:   bad drops the supply flag, only on command
`timescale 1ns/1ps
`default_nettype none
module pmc_fw_model (
	input  wire logic  i_clock,
	output logic       o_tpl_act_we,
	output logic [7:0] o_tpl_act,
	output logic       o_tpl_alt_we,
	output logic [7:0] o_tpl_alt,
	output logic       o_cpu_off,
	output logic       o_mode_we,
	output logic [1:0] o_mode_sel,
	output logic       o_io_ok,
	output logic       o_reg_off_we,
	output logic [1:0] o_reg_off,
	output logic [5:0] o_wake,
	output logic       o_reset_evt
);
	// ==========
	// strobes
	initial begin
		{o_tpl_act_we, o_tpl_act, o_tpl_alt_we, o_tpl_alt, o_cpu_off, o_mode_we} = '0;
		{o_mode_sel, o_reg_off_we, o_reg_off, o_wake, o_reset_evt} = '0;
		o_io_ok = 1'b1;
	end
	task automatic pulse(input int k, input logic [7:0] v, input logic bad);
		@(negedge i_clock);
		case (k)
			0: begin o_tpl_act = v; o_tpl_act_we = 1'b1; end
			1: begin o_tpl_alt = v; o_tpl_alt_we = 1'b1; end
			2: o_cpu_off = 1'b1;
			3: begin o_io_ok = !bad; o_mode_sel = v[1:0]; o_mode_we = 1'b1; end
			4: begin o_reg_off = v[1:0]; o_reg_off_we = 1'b1; end
			5: o_wake = v[5:0];
			default: o_reset_evt = 1'b1;
		endcase
		@(negedge i_clock);
		// data held; only strobes fall so late sampling still sees the value
		{o_tpl_act_we, o_tpl_alt_we, o_cpu_off, o_mode_we, o_reg_off_we, o_wake, o_reset_evt} = '0;
	endtask
endmodule // pmc_fw_model
`default_nettype wire

// File: test_power_mode_controller.sv
// Purpose: self-checking bench for the power mode controller
// Assumes: results are settled two edges after a strobe
// Notes:   inputs change at the falling edge only
`timescale 1ns/1ps
`default_nettype none
module test_power_mode_controller;
	import pmc_pkg::*;
	logic         clk = 1'b0;
	logic         rstn = 1'b0;
	logic         tawe, talwe, coff, mwe, iook, rwe, rev;
	logic [7:0]   tact, talt, pin_o, irq_o;
	logic [7:0]   pin = 8'hA5;
	logic [7:0]   irq = 8'h3C;
	logic [1:0]   msel, roff;
	logic [5:0]   wk;
	pmc_mode_t    mode;
	pmc_sub_ctl_t sub;
	pmc_clk_ctl_t ck;
	pmc_reg_ctl_t rg;
	logic         ret, refu;
	int           n_fail = 0;
	int           check_count = 0;
	int           n;
	pmc_fw_model fw (.i_clock(clk), .o_tpl_act_we(tawe), .o_tpl_act(tact), .o_tpl_alt_we(talwe),
		.o_tpl_alt(talt), .o_cpu_off(coff), .o_mode_we(mwe), .o_mode_sel(msel), .o_io_ok(iook),
		.o_reg_off_we(rwe), .o_reg_off(roff), .o_wake(wk), .o_reset_evt(rev));
	pmc_power_mode_ctrl dut_u (.i_clock(clk), .i_resetn(rstn), .i_tpl_act_we(tawe),
		.i_tpl_act(tact), .i_tpl_alt_we(talwe), .i_tpl_alt(talt), .i_cpu_off(coff),
		.i_mode_we(mwe), .i_mode_sel(msel), .i_io_supply_ok(iook), .i_core_reg_off_we(rwe),
		.i_core_reg_off(roff), .i_wake(wk), .i_reset_evt(rev), .i_pin_out(pin),
		.i_pin_irq_cfg(irq), .o_mode(mode), .o_sub(sub), .o_clk(ck), .o_reg(rg),
		.o_pin_out(pin_o), .o_pin_irq_cfg(irq_o), .o_retain(ret), .o_req_refused(refu));
	// ==========
	// tasks
	initial forever #2.5 clk = ~clk;
	task automatic go(input int c);
		repeat (c) @(negedge clk);
	endtask
	task automatic act(input int k, input logic [7:0] v, input logic bad = 1'b0);
		fw.pulse(k, v, bad);
		go(2);
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_mode(input pmc_mode_t got, input pmc_mode_t exp);
		chk(24'(got), 24'(exp));
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========
	// sequence
	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		stop_test();
	end
	initial begin
		go(16);
		rstn = 1'b1;
		go(4);
		chk_mode(mode, PMC_ACTIVE);
		chk({sub.clk_en, ck.fast_clocks, rg}, {8'hFF, 1'b1, 3'h6});
		act(0, 8'h5A);
		chk({sub.clk_en, sub.bias_en, sub.leak_cut}, 24'h5A5AA5);
		act(0, 8'hFF);
		act(2, 8'h00);
		chk(sub.clk_en, 8'hFE);
		act(5, 8'h08);
		chk(sub.clk_en, 8'hFF);
		act(1, 8'h3C);
		act(3, PMC_REQ_ALT);
		chk({mode, sub.clk_en}, {PMC_ALT_ACTIVE, 8'h3C});
		act(5, 8'h01);
		chk({mode, sub.clk_en}, {PMC_ACTIVE, 8'hFF});
		// refusal stands one cycle only, so look before the next rising edge
		fw.pulse(3, PMC_REQ_SLEEP, 1'b1);
		go(1);
		chk({refu, mode}, {1'b1, PMC_ACTIVE});
		go(1);
		chk({refu, mode}, {1'b0, PMC_ACTIVE});
		// every sleep source gets its own round trip
		for (int s = 0; s < 6; s++) begin
			act(3, PMC_REQ_SLEEP);
			chk({mode, sub.clk_en, ck}, {PMC_SLEEP, 8'h00, 3'h6});
			act(5, 8'(1 << s));
			chk({mode, sub.clk_en[PMC_SUB_CPU]}, {PMC_ACTIVE, 1'b1});
		end
		act(3, PMC_REQ_SLEEP);
		n = 0;
		repeat (256) begin
			go(1);
			n += int'(rg.digital_core_supply === 1'b1);
		end
		chk(n >= 1 && n <= 2 * PMC_BUZZ_ON, 1'b1);
		act(5, 8'h20);
		act(3, PMC_REQ_HIB);
		chk({mode, ck, rg, ret}, {PMC_HIBERNATE, 3'h0, 3'h1, 1'b1});
		pin = 8'h5A;
		irq = 8'hC3;
		act(5, {2'h0, ~PMC_HIB_WK_MASK});
		chk({mode, pin_o, irq_o}, {PMC_HIBERNATE, 8'hA5, 8'h3C});
		act(5, 8'h02);
		chk({mode, pin_o, sub.clk_en}, {PMC_ACTIVE, 8'h5A, 8'hFF});
		act(3, PMC_REQ_HIB);
		act(6, 8'h00);
		chk_mode(mode, PMC_ACTIVE);
		act(4, 8'h03);
		chk(rg, 3'h0);
		stop_test();
	end
endmodule // test_power_mode_controller
`default_nettype wire
